// file: mrf_pkg.sv
// package for the rtu slave framer: register map, fields, timing
// assumes classic wishbone slave with 32-bit data, byte addresses
package mrf_pkg;
    // register byte offsets
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_STAT = 8'h04;
    localparam logic [7:0] ADR_RXD = 8'h08;
    localparam logic [7:0] ADR_TXD = 8'h0C;
    localparam logic [7:0] ADR_DIV = 8'h10;
    // control fields
    localparam int CTL_EN = 0;
    localparam int CTL_PAR_EN = 1;
    localparam int CTL_PAR_ODD = 2;
    localparam int CTL_SEVEN = 3;
    localparam int CTL_ADDR_LO = 8;
    localparam int CTL_ADDR_W = 8;
    // status fields
    localparam int ST_RX_VALID = 0;
    localparam int ST_FRAME_OK = 1;
    localparam int ST_CRC_ERR = 2;
    localparam int ST_PAR_ERR = 3;
    localparam int ST_BCAST = 4;
    localparam int ST_TX_BUSY = 5;
    localparam int ST_REPLY_OK = 6;
    localparam int ST_MINE = 7;
    // txd fields: bit 8 marks the last byte of a reply
    localparam int TXD_LAST = 8;
    // crc and address constants
    localparam logic [15:0] CRC_PRESET = 16'hFFFF;
    localparam logic [15:0] CRC_POLY = 16'hA001;
    localparam logic [7:0] ADDR_BCAST = 8'h00;
    localparam logic [7:0] ADDR_MAX = 8'hF7;
    localparam logic [7:0] RST_ADDR = 8'h01;
    // clock 200 MHz, 9600 bit/s default: 20833 clocks per bit
    localparam int CLK_HZ = 200_000_000;
    localparam int BAUD_DEF = 9600;
    localparam logic [15:0] DIV_DEF = 16'(CLK_HZ / BAUD_DEF);
    // gaps in half-bit units of an 11-bit character
    localparam int CHAR_BITS = 11;
    localparam logic [7:0] GAP15_HB = 8'(CHAR_BITS * 3);
    localparam logic [7:0] GAP35_HB = 8'(CHAR_BITS * 7);
    localparam logic [3:0] STOP_TWO = 4'h2;
    localparam logic [3:0] STOP_ONE = 4'h1;
    localparam logic [31:0] RD_ZERO = 32'h0000_0000;
endpackage

// file: mrf_framer.sv
// rtu slave framer: uart rx/tx, gap timing, address filter, crc-16
// assumes a wishbone master on clk_i and an rs485 transceiver on the pins
//
// Local design decisions: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// RQ1 - half duplex line, binary framing only
// RQ2 - start bit, 7/8 data bits, lsb first
// RQ3 - one parity bit only when enabled
// RQ4 - one stop with parity, two without
// RQ5 - eleven or ten bit characters with parity
// RQ6 - transmitter keeps 3.5 character idle around frames
// RQ7 - receiver ends frame after 3.5 character idle
// RQ8 - gap over 1.5 chars discards partial frame
// RQ9 - early character appends to previous frame
// RQ10 - first byte after gap is address
// RQ11 - address 0 to 247, zero broadcasts
// RQ12 - second byte is command code
// RQ13 - payload is 2*N bytes
// RQ14 - crc field low byte then high
// RQ15 - even parity makes ones count even
// RQ16 - odd parity makes ones count odd
// RQ17 - parity checked on every received character
// RQ18 - crc mismatch flags communication error
// RQ19 - crc preset FFFF, bytes in order
// RQ20 - only data bits enter crc
// RQ21 - stations share settings, unique addresses
// RQ22 - transmit only in reply to command
// RQ23 - unicast answered, broadcast never answered
// RQ24 - crc uses reflected polynomial A001
// RQ25 - programmable divider sets bit timing
module mrf_framer #(
    parameter logic [15:0] DIV_RESET = mrf_pkg::DIV_DEF
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic rs485_rx_i,
    output logic rs485_tx_o,
    output logic rs485_de_o
);
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} mrf_rx_e;
    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} mrf_tx_e;

    typedef struct packed {
        logic [1:0] sync;
        logic [7:0] ctrl;
        logic [7:0] addr;
        logic [15:0] div;
        logic [15:0] hb_cnt;
        logic hb_tick_en;
        logic [7:0] idle_hb;
        logic in_frame;
        logic long_gap;
        logic got_addr;
        logic mine;
        logic bcast;
        logic [15:0] rx_crc;
        logic [15:0] rx_tail;
        logic [7:0] rx_count;
        logic par_err;
        logic crc_err;
        logic frame_ok;
        logic reply_ok;
        logic [7:0] rx_byte;
        logic rx_valid;
        mrf_rx_e rx_st;
        logic [4:0] rx_hb;
        logic [3:0] rx_bit;
        logic [7:0] rx_sh;
        logic rx_par;
        mrf_tx_e tx_st;
        logic [4:0] tx_hb;
        logic [3:0] tx_bit;
        logic [7:0] tx_sh;
        logic tx_par;
        logic tx_last;
        logic tx_pend;
        logic [15:0] tx_crc;
        logic [1:0] tx_crc_ph;
        logic tx_o;
        logic de_o;
        logic ack;
        logic [31:0] dat;
    } mrf_state_s;

    mrf_state_s q, d;

    // one reflected crc-16 byte step
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {8'h00, b}; // RQ20
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ mrf_pkg::CRC_POLY) : (r >> 1); // RQ24
        end
        return r;
    endfunction

    logic rx_pin;
    logic half_tick;
    logic bus_req;
    logic [3:0] nbits;
    assign rx_pin = q.sync[1];
    assign half_tick = q.hb_tick_en;
    assign bus_req = wb_cyc_i && wb_stb_i && !q.ack;
    assign nbits = q.ctrl[mrf_pkg::CTL_SEVEN] ? 4'd7 : 4'd8; // RQ2

    always_comb begin
        d = q;
        d.sync = {q.sync[0], rs485_rx_i};
        d.rx_valid = 1'b0;
        d.ack = 1'b0;
        // half-bit timebase; the divider sets the baud rate
        d.hb_tick_en = 1'b0;
        if (q.hb_cnt >= {1'b0, q.div[15:1]}) begin // RQ25
            d.hb_cnt = 16'h0001;
            d.hb_tick_en = 1'b1;
        end else begin
            d.hb_cnt = q.hb_cnt + 16'h0001;
        end
        // idle gap counter counts quiet half bits, cleared while receiving, holds at FF
        if (q.rx_st != RX_IDLE || !rx_pin) begin // RQ7
            d.idle_hb = 8'h00;
        end else if (half_tick && q.idle_hb != 8'hFF) begin
            d.idle_hb = q.idle_hb + 8'h01;
        end
        if (q.idle_hb > mrf_pkg::GAP15_HB) d.long_gap = 1'b1; // RQ8
        // frame end after 3.5 character idle
        if (q.in_frame && q.idle_hb >= mrf_pkg::GAP35_HB) begin // RQ7
            d.in_frame = 1'b0;
            d.frame_ok = q.got_addr && q.rx_count >= 8'h04 && !q.rx_count[0] && // RQ12 RQ13
                q.rx_tail == q.rx_crc && !q.par_err;
            d.crc_err = q.rx_tail != q.rx_crc; // RQ18
            d.reply_ok = q.mine && !q.bcast && q.rx_tail == q.rx_crc && !q.par_err; // RQ23
            d.tx_crc = mrf_pkg::CRC_PRESET; // RQ19
        end
        // receiver state machine, sample at mid bit
        case (q.rx_st)
            RX_IDLE: begin
                if (!rx_pin && q.ctrl[mrf_pkg::CTL_EN] && !q.de_o) begin // RQ1
                    d.rx_st = RX_START;
                    if (!q.in_frame || q.long_gap) d.par_err = 1'b0;
                    d.rx_hb = 5'd0;
                end
            end
            RX_START: begin
                if (half_tick) begin
                    d.rx_st = rx_pin ? RX_IDLE : RX_DATA;
                    d.rx_hb = 5'd0;
                    d.rx_bit = 4'd0;
                    d.rx_par = 1'b0;
                    d.rx_sh = 8'h00;
                end
            end
            RX_DATA: begin
                if (half_tick) begin
                    d.rx_hb = q.rx_hb + 5'd1;
                    if (q.rx_hb[0]) begin
                        d.rx_sh = {rx_pin, q.rx_sh[7:1]}; // RQ2
                        d.rx_par = q.rx_par ^ rx_pin;
                        d.rx_bit = q.rx_bit + 4'd1;
                        if (q.rx_bit + 4'd1 == nbits) begin
                            d.rx_st = q.ctrl[mrf_pkg::CTL_PAR_EN] ? RX_PAR : RX_STOP; // RQ3
                        end
                    end
                end
            end
            RX_PAR: begin
                if (half_tick) begin
                    d.rx_hb = q.rx_hb + 5'd1;
                    if (q.rx_hb[0]) begin
                        // even: ones total even; odd: ones total odd
                        if ((q.rx_par ^ rx_pin) != q.ctrl[mrf_pkg::CTL_PAR_ODD]) begin // RQ15 RQ16
                            d.par_err = 1'b1; // RQ17
                        end
                        d.rx_st = RX_STOP;
                    end
                end
            end
            RX_STOP: begin
                if (half_tick) begin
                    d.rx_hb = q.rx_hb + 5'd1;
                    if (q.rx_hb[0]) begin
                        d.rx_st = RX_IDLE;
                        d.rx_valid = 1'b1;
                        d.rx_byte = q.ctrl[mrf_pkg::CTL_SEVEN] ? {1'b0, q.rx_sh[7:1]} : q.rx_sh;
                    end
                end
            end
            default: d.rx_st = RX_IDLE;
        endcase
        // frame assembly on each received character
        if (q.rx_valid) begin
            if (!q.in_frame || q.long_gap) begin
                // fresh frame: gap latched before the start bit, stale partial dropped
                d.in_frame = 1'b1; // RQ8
                d.got_addr = 1'b1; // RQ10
                d.rx_count = 8'h01;
                d.rx_crc = mrf_pkg::CRC_PRESET; // RQ19
                d.rx_tail = {q.rx_byte, 8'h00};
                d.bcast = q.rx_byte == mrf_pkg::ADDR_BCAST; // RQ11
                d.mine = q.rx_byte == mrf_pkg::ADDR_BCAST ||
                    (q.rx_byte == q.addr && q.rx_byte <= mrf_pkg::ADDR_MAX);
                d.long_gap = 1'b0;
                d.frame_ok = 1'b0;
                d.crc_err = 1'b0;
                d.reply_ok = 1'b0;
            end else begin
                // appended; crc lags two bytes so the tail is the check field
                d.rx_count = q.rx_count + 8'h01; // RQ9
                d.rx_tail = {q.rx_byte, q.rx_tail[15:8]}; // RQ14
                if (q.rx_count >= 8'h02) begin
                    d.rx_crc = crc_step(q.rx_crc, q.rx_tail[7:0]); // RQ19
                end
            end
        end
        // wishbone register access
        if (bus_req) begin
            d.ack = 1'b1;
            d.dat = mrf_pkg::RD_ZERO;
            case (wb_adr_i)
                mrf_pkg::ADR_CTRL: begin
                    d.dat = {16'h0000, q.addr, q.ctrl};
                    if (wb_we_i && wb_sel_i[0]) d.ctrl = wb_dat_i[7:0];
                    if (wb_we_i && wb_sel_i[1]) d.addr = wb_dat_i[15:8];
                end
                mrf_pkg::ADR_STAT: begin
                    d.dat[mrf_pkg::ST_FRAME_OK] = q.frame_ok;
                    d.dat[mrf_pkg::ST_CRC_ERR] = q.crc_err;
                    d.dat[mrf_pkg::ST_PAR_ERR] = q.par_err;
                    d.dat[mrf_pkg::ST_BCAST] = q.bcast;
                    d.dat[mrf_pkg::ST_TX_BUSY] = q.tx_pend || q.de_o || q.tx_crc_ph != 2'h0;
                    d.dat[mrf_pkg::ST_REPLY_OK] = q.reply_ok;
                    d.dat[mrf_pkg::ST_MINE] = q.mine;
                    d.dat[mrf_pkg::ST_RX_VALID] = q.in_frame;
                end
                mrf_pkg::ADR_RXD: d.dat = {24'h00_0000, q.rx_byte};
                mrf_pkg::ADR_TXD: begin
                    // only a pending unicast reply may be sent
                    if (wb_we_i && wb_sel_i[0] && q.reply_ok && !q.tx_pend && !q.de_o) begin // RQ22 RQ23
                        d.tx_sh = wb_dat_i[7:0];
                        d.tx_last = wb_dat_i[mrf_pkg::TXD_LAST];
                        d.tx_pend = 1'b1;
                    end
                end
                mrf_pkg::ADR_DIV: begin
                    d.dat = {16'h0000, q.div};
                    if (wb_we_i && wb_sel_i[0]) d.div[7:0] = wb_dat_i[7:0];
                    if (wb_we_i && wb_sel_i[1]) d.div[15:8] = wb_dat_i[15:8];
                end
                default: d.dat = mrf_pkg::RD_ZERO;
            endcase
        end
        // transmitter; waits 3.5 chars of quiet before starting
        case (q.tx_st)
            TX_IDLE: begin
                d.tx_o = 1'b1;
                if ((q.tx_pend || ^q.tx_crc_ph) && q.idle_hb >= mrf_pkg::GAP35_HB && half_tick) begin // RQ6
                    if (q.tx_crc_ph == 2'd1) d.tx_sh = q.tx_crc[7:0]; // RQ14
                    if (q.tx_crc_ph == 2'd2) d.tx_sh = q.tx_crc[15:8];
                    d.tx_st = TX_START;
                    d.de_o = 1'b1;
                    d.tx_hb = 5'd0;
                end else if (q.tx_crc_ph == 2'd3 && q.idle_hb >= mrf_pkg::GAP35_HB) begin
                    d.tx_crc_ph = 2'd0;
                    d.reply_ok = 1'b0; // one reply per command
                end
            end
            TX_START: begin
                d.tx_o = 1'b0;
                if (half_tick) begin
                    d.tx_hb = q.tx_hb + 5'd1;
                    if (q.tx_hb[0]) begin
                        d.tx_st = TX_DATA;
                        d.tx_bit = 4'd0;
                        d.tx_par = 1'b0;
                        if (q.tx_crc_ph == 2'd0) d.tx_crc = crc_step(q.tx_crc, q.tx_sh); // RQ19
                    end
                end
            end
            TX_DATA: begin
                d.tx_o = q.tx_sh[0]; // RQ2
                if (half_tick) begin
                    d.tx_hb = q.tx_hb + 5'd1;
                    if (q.tx_hb[0]) begin
                        d.tx_sh = {1'b0, q.tx_sh[7:1]};
                        d.tx_par = q.tx_par ^ q.tx_sh[0];
                        d.tx_bit = q.tx_bit + 4'd1;
                        if (q.tx_bit + 4'd1 == nbits) begin
                            d.tx_st = q.ctrl[mrf_pkg::CTL_PAR_EN] ? TX_PAR : TX_STOP; // RQ3
                            d.tx_bit = q.ctrl[mrf_pkg::CTL_PAR_EN] ? mrf_pkg::STOP_ONE : mrf_pkg::STOP_TWO; // RQ4
                        end
                    end
                end
            end
            TX_PAR: begin
                d.tx_o = q.tx_par ^ q.ctrl[mrf_pkg::CTL_PAR_ODD]; // RQ15 RQ16
                if (half_tick) begin
                    d.tx_hb = q.tx_hb + 5'd1;
                    if (q.tx_hb[0]) d.tx_st = TX_STOP;
                end
            end
            TX_STOP: begin
                d.tx_o = 1'b1;
                if (half_tick) begin
                    d.tx_hb = q.tx_hb + 5'd1;
                    if (q.tx_hb[0]) begin
                        d.tx_bit = q.tx_bit - 4'd1;
                        if (q.tx_bit == 4'd1) begin // RQ5
                            d.tx_st = TX_IDLE;
                            d.de_o = 1'b0; // RQ1
                            d.tx_pend = 1'b0;
                            if (q.tx_crc_ph != 2'd0) d.tx_crc_ph = q.tx_crc_ph + 2'd1;
                            else if (q.tx_last) d.tx_crc_ph = 2'd1;
                        end
                    end
                end
            end
            default: d.tx_st = TX_IDLE;
        endcase
    end

    // single state register; ce_i freezes everything
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            q <= '0;
            q.sync <= 2'b11;
            q.div <= DIV_RESET;
            q.addr <= mrf_pkg::RST_ADDR;
            q.rx_crc <= mrf_pkg::CRC_PRESET;
            q.tx_crc <= mrf_pkg::CRC_PRESET;
            q.tx_o <= 1'b1;
            q.rx_st <= RX_IDLE;
            q.tx_st <= TX_IDLE;
        end else if (ce_i) begin
            q <= d;
        end
    end

    assign wb_dat_o = q.dat;
    assign wb_ack_o = q.ack;
    assign rs485_tx_o = q.tx_o;
    assign rs485_de_o = q.de_o;

    // a broadcast never leaves a reply pending
    a_bcast_no_reply: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        q.bcast && !q.in_frame |-> !q.reply_ok) else $error("broadcast answered"); // RQ23
    // driver only enabled after a reply was allowed
    a_tx_only_reply: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        $rose(q.de_o) |-> $past(q.reply_ok)) else $error("unsolicited transmit"); // RQ22
    // the line idles high while not driving
    a_line_idle_high: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !q.de_o |=> rs485_tx_o || q.tx_st != TX_IDLE) else $error("line low while idle"); // RQ1
    // a start bit is low
    a_start_bit_low: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        q.tx_st == TX_START && ce_i |=> !rs485_tx_o || q.tx_st != TX_START) else $error("start not low"); // RQ2
    // driving begins only after full idle gap
    a_gap_before_tx: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        $rose(q.de_o) |-> $past(q.idle_hb) >= mrf_pkg::GAP35_HB) else $error("gap too short"); // RQ6
    // a new frame starts from the preset crc
    a_crc_preset: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RQ19
        q.rx_valid && ce_i && !q.in_frame |=> q.rx_count == 8'h01 && q.rx_crc == mrf_pkg::CRC_PRESET)
        else $error("frame not restarted");
    // frame closes after the 3.5 character gap
    a_frame_closes: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        q.in_frame && q.idle_hb >= mrf_pkg::GAP35_HB && ce_i && !q.rx_valid |=> !q.in_frame)
        else $error("frame not closed"); // RQ7
    // bus ack lasts one cycle
    a_ack_pulse: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        wb_ack_o |=> !wb_ack_o) else $error("ack stuck");
endmodule
`default_nettype wire

// file: mrf_master_model.sv
// master side of the rtu link: sends characters, decodes the slave's replies
// assumes the slave divider equals DIV and the bus idles high when nobody drives
`timescale 1ns/1ps
`default_nettype none
module mrf_master_model #(
    parameter int DIV = 16
) (
    input wire logic clk_i,
    input wire logic tx_line_i,
    input wire logic de_i,
    input wire logic par_en_i,
    input wire logic par_odd_i,
    input wire logic seven_i,
    output logic line_o
);
    logic [7:0] rx_q[$];
    int gap_q[$];
    int idle_cnt = 0;
    int bad = 0;
    initial line_o = 1'b1;
    // one bit time, changed only right after an edge
    task automatic put_bit(input logic v);
        line_o <= v;
        repeat (DIV) @(posedge clk_i);
    endtask
    // one character; flip spoils the parity bit on purpose
    task automatic send_byte(input logic [7:0] b, input logic flip);
        logic p;
        p = par_odd_i;
        put_bit(1'b0);
        for (int i = 0; i < (seven_i ? 7 : 8); i++) begin
            put_bit(b[i]);
            p ^= b[i];
        end
        if (par_en_i) put_bit(p ^ flip);
        put_bit(1'b1);
        if (!par_en_i) put_bit(1'b1);
    endtask
    // idle time on the bus, both directions; a gap shorter than 3.5 chars is seen here
    always @(posedge clk_i) idle_cnt <= (!line_o || (de_i && !tx_line_i)) ? 0 : idle_cnt + 1;
    // reply decoder, samples mid bit; parity or stop faults are counted
    initial begin
        logic [7:0] d;
        logic p;
        forever begin
            @(posedge clk_i iff (de_i === 1'b1 && tx_line_i === 1'b0));
            gap_q.push_back(idle_cnt);
            d = 8'h00;
            p = par_odd_i;
            repeat (DIV / 2) @(posedge clk_i);
            for (int i = 0; i < (seven_i ? 7 : 8); i++) begin
                repeat (DIV) @(posedge clk_i);
                d[i] = tx_line_i;
                p ^= tx_line_i;
            end
            if (par_en_i) begin
                repeat (DIV) @(posedge clk_i);
                if (tx_line_i !== p) bad++;
            end
            for (int s = 0; s < (par_en_i ? 1 : 2); s++) begin
                repeat (DIV) @(posedge clk_i);
                if (tx_line_i !== 1'b1) bad++;
            end
            rx_q.push_back(d);
        end
    end
endmodule
`default_nettype wire

// file: tb_modbus_rtu_slave_framer.sv
// self-checking bench for the rtu slave framer, registers over wishbone
// assumes mrf_pkg, mrf_framer and the master model; divider shortened to DIV
`timescale 1ns/1ps
`default_nettype none
module tb_modbus_rtu_slave_framer;
    localparam int DIV = 16;
    localparam int GAP = 77 * DIV / 2;
    localparam int TAIL = GAP + 8 * DIV;
    localparam logic [31:0] F_OK = 32'h1 << mrf_pkg::ST_FRAME_OK;
    localparam logic [31:0] F_CRC = 32'h1 << mrf_pkg::ST_CRC_ERR;
    localparam logic [31:0] F_PAR = 32'h1 << mrf_pkg::ST_PAR_ERR;
    localparam logic [31:0] F_BC = 32'h1 << mrf_pkg::ST_BCAST;
    localparam logic [31:0] F_RPL = 32'h1 << mrf_pkg::ST_REPLY_OK;
    localparam logic [31:0] F_MINE = 32'h1 << mrf_pkg::ST_MINE;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, rs485_tx_o, rs485_de_o, line;
    logic par_en = 1'b0, par_odd = 1'b0, seven = 1'b0;
    logic [7:0] req[$] = {8'h01, 8'h03, 8'h00, 8'h04, 8'h00, 8'h02};
    logic [7:0] rsp[$] = {8'h01, 8'h03, 8'h04};
    int miscompares = 0, checks_done = 0, cycles = 0, de_cycles = 0;
    mrf_framer #(.DIV_RESET(16'(DIV))) i_mrf_framer (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(1'b1),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rs485_rx_i(line),
        .rs485_tx_o(rs485_tx_o), .rs485_de_o(rs485_de_o));
    mrf_master_model #(.DIV(DIV)) i_mrf_master_model (.clk_i(clk_i), .tx_line_i(rs485_tx_o),
        .de_i(rs485_de_o), .par_en_i(par_en), .par_odd_i(par_odd), .seven_i(seven), .line_o(line));
    // clock, hang guard and driver-enable activity count
    always #2.5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (rs485_de_o === 1'b1) de_cycles <= de_cycles + 1;
        if (cycles == 90000) begin
            miscompares++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    // classic cycle: hold until ack is sampled, then drop for a cycle
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50) chk(32'h0, 32'h1, "no ack");
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp, input string what);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        chk(q & mask, exp, what);
    endtask
    task automatic cfg(input logic pe, input logic odd, input logic sev);
        logic [31:0] q;
        par_en <= pe;
        par_odd <= odd;
        seven <= sev;
        wb(1'b1, mrf_pkg::ADR_CTRL, {16'h0000, 8'h01, 4'h0, sev, odd, pe, 1'b1}, q);
    endtask
    function automatic logic [15:0] crc16(input logic [7:0] m[$]);
        logic [15:0] c;
        c = 16'hFFFF;
        foreach (m[i]) begin
            c ^= {8'h00, m[i]};
            repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
        end
        return c;
    endfunction
    task automatic send_frame(input logic [7:0] m[$], input logic good, input int tail);
        logic [15:0] c;
        c = crc16(m) ^ {15'h0000, !good};
        foreach (m[i]) i_mrf_master_model.send_byte(m[i], 1'b0);
        i_mrf_master_model.send_byte(c[7:0], 1'b0);
        i_mrf_master_model.send_byte(c[15:8], 1'b0);
        repeat (tail) @(posedge clk_i);
    endtask
    task automatic t_regs();
        logic [31:0] q;
        rd(mrf_pkg::ADR_CTRL, 32'hFFFF_FFFF, {16'h0000, mrf_pkg::RST_ADDR, 8'h00}, "ctrl reset");
        rd(mrf_pkg::ADR_DIV, 32'h0000_FFFF, 32'(DIV), "div reset");
        chk({30'h0, rs485_tx_o, rs485_de_o}, 32'h0000_0002, "idle line");
        wb(1'b1, 8'h20, 32'hFFFF_FFFF, q);
        rd(8'h20, 32'hFFFF_FFFF, 32'h0000_0000, "unmapped");
        wb(1'b1, mrf_pkg::ADR_CTRL, 32'h0000_010F, q);
        rd(mrf_pkg::ADR_CTRL, 32'h0000_FFFF, 32'h0000_010F, "ctrl readback");
        $display("register test done");
    endtask
    // good unicast, then a three byte reply with appended check field
    task automatic t_unicast();
        logic [31:0] q;
        logic [15:0] c;
        logic [7:0] e[$];
        int n;
        cfg(1'b1, 1'b0, 1'b0);
        send_frame(req, 1'b1, TAIL);
        rd(mrf_pkg::ADR_STAT, F_OK | F_CRC | F_PAR | F_BC | F_RPL | F_MINE, F_OK | F_RPL | F_MINE, "unicast");
        c = crc16(req);
        rd(mrf_pkg::ADR_RXD, 32'h0000_00FF, {24'h0, c[15:8]}, "last byte");
        i_mrf_master_model.gap_q.delete();
        foreach (rsp[i]) begin
            wb(1'b1, mrf_pkg::ADR_TXD, {23'h0, 1'(i == rsp.size() - 1), rsp[i]}, q);
            n = 0;
            do begin
                wb(1'b0, mrf_pkg::ADR_STAT, 32'h0, q);
                n++;
            end while (q[mrf_pkg::ST_TX_BUSY] !== 1'b0 && n < 3000);
        end
        n = 0;
        while (i_mrf_master_model.rx_q.size() < 5 && n < 3000) begin
            @(posedge clk_i);
            n++;
        end
        c = crc16(rsp);
        e = {rsp, c[7:0], c[15:8]};
        chk(32'(i_mrf_master_model.rx_q.size()), 32'd5, "reply length");
        foreach (e[i]) chk({24'h0, i_mrf_master_model.rx_q[i]}, {24'h0, e[i]}, "reply byte");
        chk(32'(i_mrf_master_model.gap_q[0] >= GAP), 32'h1, "gap before reply");
        chk(32'(i_mrf_master_model.bad), 32'h0, "reply character format");
        repeat (TAIL) @(posedge clk_i);
        $display("unicast test done");
    endtask
    // bad check field, broadcast, foreign address: none may be answered
    task automatic t_reject();
        logic [31:0] q, e[3];
        logic [7:0] m[$];
        int d0;
        e = '{F_CRC, F_BC, 32'h0};
        cfg(1'b0, 1'b0, 1'b0);
        for (int k = 0; k < 3; k++) begin
            m = req;
            m[0] = k == 1 ? 8'h00 : (k == 2 ? 8'h05 : 8'h01);
            send_frame(m, k != 0, TAIL);
            rd(mrf_pkg::ADR_STAT, F_CRC | F_BC | F_RPL, e[k], "reject status");
            d0 = de_cycles;
            i_mrf_master_model.rx_q.delete();
            wb(1'b1, mrf_pkg::ADR_TXD, 32'h0000_0155, q);
            repeat (TAIL) @(posedge clk_i);
            chk(32'(de_cycles - d0 + i_mrf_master_model.rx_q.size()), 32'h0, "silent");
        end
        $display("reject test done");
    endtask
    // even and odd parity at both widths; one spoiled parity bit must be flagged
    task automatic t_parity();
        for (int k = 0; k < 4; k++) begin
            cfg(1'b1, k[0], k[1]);
            for (int b = 0; b < 2; b++) begin
                for (int i = 0; i < 4; i++) i_mrf_master_model.send_byte(req[i], 1'(b == 1 && i == 2));
                repeat (TAIL) @(posedge clk_i);
                rd(mrf_pkg::ADR_STAT, F_PAR, b == 1 ? F_PAR : 32'h0, "parity flag");
            end
        end
        $display("parity test done");
    endtask
    // 2.5 char gap drops a partial frame; a short gap merges two frames
    task automatic t_gaps();
        cfg(1'b0, 1'b0, 1'b0);
        for (int i = 0; i < 3; i++) i_mrf_master_model.send_byte(req[i], 1'b0);
        repeat (5 * 11 * DIV / 2) @(posedge clk_i);
        send_frame(req, 1'b1, TAIL);
        rd(mrf_pkg::ADR_STAT, F_OK | F_CRC, F_OK, "after discard");
        send_frame(req, 1'b1, 11 * DIV / 2);
        send_frame(req, 1'b1, TAIL);
        rd(mrf_pkg::ADR_STAT, F_OK | F_CRC, F_CRC, "merged frames");
        $display("gap test done");
    endtask
    initial begin
        repeat (6) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_i);
        t_regs();
        t_unicast();
        t_reject();
        t_parity();
        t_gaps();
        tally_and_finish();
    end
endmodule
`default_nettype wire
